/* bench/fpbs_far_reader.sv */
/*
  Far-side port-B reader: raises the read enable while data is pending,
  up to a read budget, promptly or with random stalls.
  Assumes the sizer's clock and reset, and that refused reads are harmless.
*/
`timescale 1ns/100ps
module fpbs_far_reader (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Control from the bench
  input  wire logic       i_slow,
  input  wire logic       i_budget_load,
  input  wire logic [7:0] i_budget,
  // Port handshake
  input  wire logic       i_data_pending,
  output logic            o_read_en
);
  logic [7:0] budget;     // Reads still allowed
  logic [7:0] left;       // Budget after this edge
  int         seed;       // Stall pattern source
  int         r;          // Last random draw
  initial seed = 32'hb5af;
  ////////////////////////////////////////////////////////////////////////////
  // Enable changes only just after a rising edge, so the sizer samples a
  // settled level; a read counts once it meets pending data
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      budget    <= 8'h0;
      o_read_en <= 1'b0;
    end else begin
      r = $random(seed);
      if (i_budget_load) begin
        left = i_budget;
      end else if (o_read_en && i_data_pending && budget != 8'h0) begin
        left = budget - 8'h1;
      end else begin
        left = budget;
      end
      budget    <= left;
      // Stalls only when slow; idle enable is low, never a stale level
      o_read_en <= (left != 8'h0) && i_data_pending && (!i_slow || r[0]);
    end
  end
endmodule // fpbs_far_reader

/* bench/tb_top.sv */
/*
  Self-checking bench of the port-B read sizer: every width, order and
  swap, FIFO fill and drain, mailbox freeze and a mid-word width change.
  Assumes the far-side reader model and the design package are compiled.
*/
`timescale 1ns/100ps
module tb_top;
  // Stimulus
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_word_valid = 1'b0;
  logic [35:0] i_word_data = 36'h0;
  logic [1:0]  width_code = 2'h0;   // {hi, lo}
  logic        i_byte_order_sel_n = 1'b0;
  logic [1:0]  swap_code = 2'h0;    // {hi, lo}
  logic        slow = 1'b0;
  logic        bud_load = 1'b0;
  logic [7:0]  bud = 8'h0;
  // Observed
  logic        read_en;
  logic [35:0] o_port_data;
  logic [3:0]  o_lane_valid;
  logic        o_word_ready;
  logic        o_port_valid;
  logic        o_data_pending;
  // Bookkeeping: notes are {lanes, data}
  int          mismatches = 0;
  int          num_checks = 0;
  int          seed = 32'hb5af;
  logic [39:0] exp_q[$];
  logic [39:0] mon_cur;
  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  always #50 i_sys_clk = ~i_sys_clk;
  fpbs_read_sizer dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_word_valid(i_word_valid),
    .i_word_data(i_word_data), .o_word_ready(o_word_ready),
    .i_width_sel_lo(width_code[0]), .i_width_sel_hi(width_code[1]),
    .i_byte_order_sel_n(i_byte_order_sel_n), .i_swap_sel_lo(swap_code[0]),
    .i_swap_sel_hi(swap_code[1]), .i_read_en(read_en), .o_port_data(o_port_data),
    .o_lane_valid(o_lane_valid), .o_port_valid(o_port_valid),
    .o_data_pending(o_data_pending));
  fpbs_far_reader reader (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_slow(slow), .i_budget_load(bud_load),
    .i_budget(bud), .i_data_pending(o_data_pending), .o_read_en(read_en));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Expected pieces of one word; take cuts the list when a piece is lost
  task automatic note(input logic [35:0] w, input logic [1:0] code, input logic ord,
                      input logic [1:0] sw, input int take);
    logic [35:0] s;
    logic [39:0] p[4];
    int          n;
    case (sw)
      2'h1:    s = {w[8:0], w[17:9], w[26:18], w[35:27]};
      2'h2:    s = {w[17:0], w[35:18]};
      2'h3:    s = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: s = w;
    endcase
    n = 4;
    for (int i = 0; i < 4; i++) begin
      if (code == fpbs_pkg::SEL_BYTE && !ord) begin
        p[i] = {fpbs_pkg::LANES_BYTE_BE, s[35-9*i -: 9], 27'h0};
      end else begin
        p[i] = {fpbs_pkg::LANES_BYTE_LE, 27'h0, s[8+9*i -: 9]};
      end
    end
    if (code == fpbs_pkg::SEL_WORD) begin
      n = 2;
      p[0] = ord ? {fpbs_pkg::LANES_WORD_LE, 18'h0, s[17:0]}
                 : {fpbs_pkg::LANES_WORD_BE, s[35:18], 18'h0};
      p[1] = ord ? {fpbs_pkg::LANES_WORD_LE, 18'h0, s[35:18]}
                 : {fpbs_pkg::LANES_WORD_BE, s[17:0], 18'h0};
    end else if (code == fpbs_pkg::SEL_LONG) begin
      n = 1;
      p[0] = {fpbs_pkg::LANES_LONG, s};
    end
    for (int i = 0; i < n && i < take; i++) exp_q.push_back(p[i]);
  endtask
  // Offer a word and hold it until accepted or the bound runs out
  task automatic push(input logic [35:0] w, input int lim, output bit ok);
    ok = 0;
    i_word_valid <= 1'b1;
    i_word_data  <= w;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge i_sys_clk);
      ok = (o_word_ready === 1'b1);
    end
  endtask
  task automatic load_bud(input logic [7:0] n);
    bud      <= n;
    bud_load <= 1'b1;
    @(posedge i_sys_clk);
    bud_load <= 1'b0;
  endtask
  // Let the reader run until only 'left' notes remain
  task automatic run_reads(input logic [7:0] n, input int left);
    bit done;
    done = 0;
    load_bud(n);
    for (int i = 0; i < 600 && !done; i++) begin
      @(posedge i_sys_clk);
      done = (exp_q.size() == left) && (left != 0 || o_data_pending === 1'b0);
    end
    if (!done) begin
      check("drain timeout", 36'h1, 36'h0);
      end_sim();
    end
  endtask
  // Selects go out one cycle before use; two edges leave margin
  task automatic set_cfg(input logic [1:0] code, input logic ord, input logic [1:0] sw);
    width_code         <= code;
    i_byte_order_sel_n <= ord;
    swap_code          <= sw;
    repeat (2) @(posedge i_sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scoreboard: every piece pulse takes the oldest note
  always @(posedge i_sys_clk) begin
    if (o_port_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected piece", 36'h1, 36'h0);
      end else begin
        mon_cur = exp_q.pop_front();
        check("port data", o_port_data, mon_cur[35:0]);
        check("lane valid", {32'h0, o_lane_valid}, {32'h0, mon_cur[39:36]});
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin : main
    logic [35:0] w;
    bit          ok;
    int          cnt;
    int          r;
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    check("ready after reset", {35'h0, o_word_ready}, 36'h1);
    check("pending after reset", {35'h0, o_data_pending}, 36'h0);
    // Every width, order and swap, two words back to back
    for (int c = 0; c < 3; c++) begin
      for (int k = 0; k < 8; k++) begin
        set_cfg(2'(c), k[2], k[1:0]);
        r = $random(seed);
        slow <= r[0];
        for (int j = 0; j < 2; j++) begin
          w = {$random(seed), $random(seed)};
          push(w, 40, ok);
          if (!ok) check("word refused", 36'h1, 36'h0);
          note(w, 2'(c), k[2], k[1:0], 4);
        end
        i_word_valid <= 1'b0;
        run_reads(8'd100, 0);
      end
    end
    $display("test sweep done");
    // Fill the staging queue with no reads, then drain with stalls
    set_cfg(fpbs_pkg::SEL_BYTE, 1'b0, 2'h0);
    load_bud(8'h0);
    cnt = 0;
    ok  = 1;
    while (ok && cnt < 8) begin
      w = {$random(seed), $random(seed)};
      push(w, 4, ok);
      if (ok) note(w, fpbs_pkg::SEL_BYTE, 1'b0, 2'h0, 4);
      if (ok) cnt++;
    end
    i_word_valid <= 1'b0;
    check("ready when full", {35'h0, o_word_ready}, 36'h0);
    check("words held", 36'(cnt >= fpbs_pkg::QUEUE_DEPTH), 36'h1);
    slow <= 1'b1;
    run_reads(8'd200, 0);
    slow <= 1'b0;
    $display("test fill drain done");
    // Mailbox code in mid-word freezes the byte transfer
    set_cfg(fpbs_pkg::SEL_BYTE, 1'b1, 2'h2);
    w = {$random(seed), $random(seed)};
    push(w, 40, ok);
    i_word_valid <= 1'b0;
    note(w, fpbs_pkg::SEL_BYTE, 1'b1, 2'h2, 4);
    run_reads(8'd1, 3);
    width_code <= fpbs_pkg::SEL_MAILBOX;
    load_bud(8'd20);
    repeat (7) @(posedge i_sys_clk);
    check("pieces during mailbox", 36'(exp_q.size()), 36'h3);
    width_code <= fpbs_pkg::SEL_BYTE;
    run_reads(8'd20, 0);
    $display("test mailbox done");
    // Width change after two bytes drops the rest of the word
    w = {$random(seed), $random(seed)};
    push(w, 40, ok);
    i_word_valid <= 1'b0;
    note(w, fpbs_pkg::SEL_BYTE, 1'b1, 2'h2, 4);
    run_reads(8'd2, 2);
    // The two pieces left behind are lost; any that still appear are flagged
    exp_q.delete();
    width_code <= fpbs_pkg::SEL_LONG;
    repeat (3) @(posedge i_sys_clk);
    check("pending after size change", {35'h0, o_data_pending}, 36'h0);
    w = {$random(seed), $random(seed)};
    push(w, 40, ok);
    i_word_valid <= 1'b0;
    note(w, fpbs_pkg::SEL_LONG, 1'b1, 2'h2, 4);
    run_reads(8'd5, 0);
    $display("test size change done");
    end_sim();
  end
endmodule // tb_top

/* hw/fpbs_pkg.sv */
/*
  Shared constants and types of the port-B read-path bus-sizing block.
  Assumes nothing: included first in compile order.
*/
package fpbs_pkg;
  // Word and lane geometry
  localparam int unsigned WORD_W     = 36;          // Whole queue word
  localparam int unsigned LANE_W     = 9;           // One byte lane
  localparam int unsigned HALF_W     = 18;          // One half-word
  localparam int unsigned QUEUE_DEPTH = 4;          // Staging FIFO words

  // Size-select codes {hi, lo}
  localparam logic [1:0] SEL_LONG    = 2'h0;
  localparam logic [1:0] SEL_WORD    = 2'h1;
  localparam logic [1:0] SEL_BYTE    = 2'h2;
  localparam logic [1:0] SEL_MAILBOX = 2'h3;

  // Swap-select codes {hi, lo}
  localparam logic [1:0] SWAP_NONE      = 2'h0;
  localparam logic [1:0] SWAP_BYTE      = 2'h1;
  localparam logic [1:0] SWAP_WORD      = 2'h2;
  localparam logic [1:0] SWAP_BYTE_WORD = 2'h3;

  // Pieces left after the fetching clock
  localparam logic [1:0] LEFT_BYTE = 2'h3;
  localparam logic [1:0] LEFT_WORD = 2'h1;
  localparam logic [1:0] LEFT_NONE = 2'h0;

  // Lane-valid patterns, bit 3 is bits 35..27
  localparam logic [3:0] LANES_LONG    = 4'hf;
  localparam logic [3:0] LANES_WORD_BE = 4'hc;
  localparam logic [3:0] LANES_WORD_LE = 4'h3;
  localparam logic [3:0] LANES_BYTE_BE = 4'h8;
  localparam logic [3:0] LANES_BYTE_LE = 4'h1;
  localparam logic [3:0] LANES_NONE    = 4'h0;

  // Applied transfer width
  typedef enum logic [1:0] {WID_LONG, WID_WORD, WID_BYTE} fpbs_width_type;

  // Values after reset
  localparam fpbs_width_type RST_WIDTH = WID_LONG;
  localparam logic           RST_ORDER = 1'b0;      // Big endian
  localparam logic [1:0]     RST_SWAP  = SWAP_NONE;
endpackage

/* hw/fpbs_queue.sv */
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module fpbs_queue #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Word storage
  logic [PW:0]      wr_ptr;        // Write pointer with wrap bit
  logic [PW:0]      rd_ptr;        // Read pointer with wrap bit
  logic [PW:0]      next_wr_ptr;
  logic [PW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign o_in_ready  = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
  assign o_out_valid = (wr_ptr != rd_ptr);
  assign o_out_data  = mem[rd_ptr[PW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointer advance
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= i_in_data;
    end
  end
endmodule // fpbs_queue

/* hw/fpbs_read_sizer.sv */
/*
  Port-B read path: outbound-queue words are staged, fetched whole and
  sent out whole in long width or split into byte or half-word pieces in the chosen order.
  Assumes i_sys_clk is the free-running second port clock and that the
  word source stalls on o_word_ready.
*/
// Overview of operation
// - Byte, half-word and whole-word widths, selectable order
// - Selects captured each edge, applied next cycle
// - Size code decodes long, byte or word
// - Word width lanes: upper or lower half
// - Big-endian bytes A..D on top lane
// - Little-endian bytes D..A on bottom lane
// - Big-endian words: upper half first
// - Little-endian words: lower half first
// - Sizing done in registers after array read
// - Two latch banks fetched and drained alternately
// - Memory side moves whole words only
// - Long width: one whole word per read
// - Fetch loads four lanes by selects and swap
// - First read fetches, later reads shift out
// - Counter blocks fetches: three, one or none
// - Little-endian word: CD first, then AB
// - Four swap arrangements, any width
// - Mailbox code freezes size and counter
// - Transfers on rising edge when enabled
`timescale 1ns/100ps
module fpbs_read_sizer (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Outbound queue word source
  input  wire logic        i_word_valid,
  input  wire logic [35:0] i_word_data,
  output logic             o_word_ready,
  // Port configuration
  input  wire logic        i_width_sel_lo,
  input  wire logic        i_width_sel_hi,
  input  wire logic        i_byte_order_sel_n,
  input  wire logic        i_swap_sel_lo,
  input  wire logic        i_swap_sel_hi,
  // Port read
  input  wire logic        i_read_en,
  output logic [35:0]      o_port_data,
  output logic [3:0]       o_lane_valid,
  output logic             o_port_valid,
  output logic             o_data_pending
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]               size_sel;        // {hi, lo}
  logic                     mailbox;         // Both size selects high
  fpbs_pkg::fpbs_width_type cfg_width;       // Applied width
  logic                     cfg_little;      // Applied order, 1 = little
  logic [1:0]               cfg_swap;        // Applied swap
  fpbs_pkg::fpbs_width_type next_cfg_width;
  logic                     next_cfg_little;
  logic [1:0]               next_cfg_swap;
  logic                     size_change;     // Size differs from stored

  logic                     q_valid;         // Staging FIFO output
  logic [35:0]              q_data;
  logic                     q_ready;
  logic [35:0]              latch_bank_one;  // Even-block word
  logic [35:0]              latch_bank_two;  // Odd-block word
  logic                     bank_one_full;
  logic                     bank_two_full;
  logic                     wr_sel;          // Bank to fill next
  logic                     rd_sel;          // Bank to fetch next
  logic [35:0]              next_bank_one;
  logic [35:0]              next_bank_two;
  logic                     next_bank_one_full;
  logic                     next_bank_two_full;
  logic                     next_wr_sel;
  logic                     next_rd_sel;
  logic                     bank_avail;
  logic [35:0]              bank_word;
  logic [35:0]              sw_word;         // Bank word after swap

  logic                     read_take;       // Queue read this edge
  logic                     fetch;           // Whole-word fetch
  logic                     shift;           // Pipeline shift
  logic [1:0]               left;            // Pieces still queued
  logic [35:0]              pipe;            // Pipeline registers
  logic [35:0]              src;
  logic [1:0]               next_left;
  logic [35:0]              next_pipe;
  logic [35:0]              next_port_data;
  logic [3:0]               next_lane_valid;
  logic                     next_port_valid;

  ////////////////////////////////////////////////////////////////////////
  // Configuration capture
  assign size_sel = {i_width_sel_hi, i_width_sel_lo};
  assign mailbox  = (size_sel == fpbs_pkg::SEL_MAILBOX);

  // Decode selects; the mailbox code leaves everything as it stands
  always_comb begin
    next_cfg_width  = cfg_width;
    next_cfg_little = cfg_little;
    next_cfg_swap   = cfg_swap;
    if (!mailbox) begin
      unique case (size_sel)
        fpbs_pkg::SEL_WORD: next_cfg_width = fpbs_pkg::WID_WORD;
        fpbs_pkg::SEL_BYTE: next_cfg_width = fpbs_pkg::WID_BYTE;
        default:            next_cfg_width = fpbs_pkg::WID_LONG;
      endcase
      next_cfg_little = i_byte_order_sel_n;
      next_cfg_swap   = {i_swap_sel_hi, i_swap_sel_lo};
    end
  end

  // A real size change restarts piece tracking with the new size
  assign size_change = (next_cfg_width != cfg_width);

  // Selects sampled every edge and used one cycle later
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_width  <= fpbs_pkg::RST_WIDTH;
      cfg_little <= fpbs_pkg::RST_ORDER;
      cfg_swap   <= fpbs_pkg::RST_SWAP;
    end else begin
      cfg_width  <= next_cfg_width;
      cfg_little <= next_cfg_little;
      cfg_swap   <= next_cfg_swap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word staging and latch banks
  fpbs_queue #(
    .WIDTH (fpbs_pkg::WORD_W),
    .DEPTH (fpbs_pkg::QUEUE_DEPTH)
  ) u_queue (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_word_valid),
    .i_in_data   (i_word_data),
    .o_in_ready  (o_word_ready),
    .o_out_valid (q_valid),
    .o_out_data  (q_data),
    .i_out_ready (q_ready)
  );

  // Drain the FIFO only into the bank due next; a stalled port
  // backs all the way up to the word source
  assign q_ready    = wr_sel ? !bank_two_full : !bank_one_full;
  assign bank_avail = rd_sel ? bank_two_full : bank_one_full;
  assign bank_word  = rd_sel ? latch_bank_two : latch_bank_one;

  // Banks fill and empty in strict alternation
  always_comb begin
    next_bank_one      = latch_bank_one;
    next_bank_two      = latch_bank_two;
    next_bank_one_full = bank_one_full;
    next_bank_two_full = bank_two_full;
    next_wr_sel        = wr_sel;
    next_rd_sel        = rd_sel;
    if (q_valid && q_ready) begin
      if (wr_sel) begin
        next_bank_two      = q_data;
        next_bank_two_full = 1'b1;
      end else begin
        next_bank_one      = q_data;
        next_bank_one_full = 1'b1;
      end
      next_wr_sel = !wr_sel;
    end
    if (fetch) begin
      if (rd_sel) begin
        next_bank_two_full = 1'b0;
      end else begin
        next_bank_one_full = 1'b0;
      end
      next_rd_sel = !rd_sel;
    end
  end

  // Bank registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      latch_bank_one <= '0;
      latch_bank_two <= '0;
      bank_one_full  <= 1'b0;
      bank_two_full  <= 1'b0;
      wr_sel         <= 1'b0;
      rd_sel         <= 1'b0;
    end else begin
      latch_bank_one <= next_bank_one;
      latch_bank_two <= next_bank_two;
      bank_one_full  <= next_bank_one_full;
      bank_two_full  <= next_bank_two_full;
      wr_sel         <= next_wr_sel;
      rd_sel         <= next_rd_sel;
    end
  end

  // Swap is applied as the whole word enters the pipeline
  fpbs_swap u_swap (
    .i_word     (bank_word),
    .i_swap_sel (cfg_swap),
    .o_word     (sw_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pipeline and piece counter
  // Mailbox cycles are not queue reads, and a size change kills the
  // word in flight; that loss is the price of on-the-fly resizing
  assign read_take      = i_read_en && !mailbox;
  assign fetch          = read_take && (left == fpbs_pkg::LEFT_NONE) && bank_avail;
  assign shift          = read_take && (left != fpbs_pkg::LEFT_NONE) && !size_change;
  assign src            = fetch ? sw_word : pipe;
  assign o_data_pending = bank_avail || (left != fpbs_pkg::LEFT_NONE);

  // One piece leaves per accepted read; the same formula serves the
  // fetching clock and every shifting clock
  always_comb begin
    next_pipe       = pipe;
    next_left       = left;
    next_port_data  = o_port_data;
    next_lane_valid = o_lane_valid;
    next_port_valid = fetch || shift;
    if (fetch || shift) begin
      unique case (cfg_width)
        fpbs_pkg::WID_LONG: begin
          next_port_data  = src;
          next_lane_valid = fpbs_pkg::LANES_LONG;
          next_pipe       = '0;
        end
        fpbs_pkg::WID_WORD: begin
          if (cfg_little) begin
            next_port_data  = {18'h0, src[17:0]};
            next_pipe       = {18'h0, src[35:18]};
            next_lane_valid = fpbs_pkg::LANES_WORD_LE;
          end else begin
            next_port_data  = {src[35:18], 18'h0};
            next_pipe       = {src[17:0], 18'h0};
            next_lane_valid = fpbs_pkg::LANES_WORD_BE;
          end
        end
        fpbs_pkg::WID_BYTE: begin
          if (cfg_little) begin
            next_port_data  = {27'h0, src[8:0]};
            next_pipe       = {9'h0, src[35:9]};
            next_lane_valid = fpbs_pkg::LANES_BYTE_LE;
          end else begin
            next_port_data  = {src[35:27], 27'h0};
            next_pipe       = {src[26:0], 9'h0};
            next_lane_valid = fpbs_pkg::LANES_BYTE_BE;
          end
        end
      endcase
    end
    // Counter: loaded on fetch, counts down per shift, idle in long width
    if (size_change) begin
      next_left = fpbs_pkg::LEFT_NONE;
    end else if (fetch) begin
      unique case (cfg_width)
        fpbs_pkg::WID_BYTE: next_left = fpbs_pkg::LEFT_BYTE;
        fpbs_pkg::WID_WORD: next_left = fpbs_pkg::LEFT_WORD;
        default:            next_left = fpbs_pkg::LEFT_NONE;
      endcase
    end else if (shift) begin
      next_left = left - 2'h1;
    end
  end

  // Pipeline and output registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pipe         <= '0;
      left         <= fpbs_pkg::LEFT_NONE;
      o_port_data  <= '0;
      o_lane_valid <= fpbs_pkg::LANES_NONE;
      o_port_valid <= 1'b0;
    end else begin
      pipe         <= next_pipe;
      left         <= next_left;
      o_port_data  <= next_port_data;
      o_lane_valid <= next_lane_valid;
      o_port_valid <= next_port_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_BYTE_DECODE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (size_sel == fpbs_pkg::SEL_BYTE) |=> (cfg_width == fpbs_pkg::WID_BYTE))
    else $error("byte size select not applied next cycle");
  AST_MAILBOX_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    mailbox |=> $stable(cfg_width) && $stable(left))
    else $error("mailbox code disturbed size or counter");
  AST_LONG_NO_COUNT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cfg_width == fpbs_pkg::WID_LONG) |-> (left == fpbs_pkg::LEFT_NONE))
    else $error("counter active in long width");
  AST_BYTE_BLOCK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (fetch && cfg_width == fpbs_pkg::WID_BYTE && !size_change) |=> (left == 2'h3))
    else $error("byte fetch did not block three more clocks");
  AST_NO_FETCH_BUSY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (left != fpbs_pkg::LEFT_NONE) |=> $stable(rd_sel))
    else $error("memory fetch while pieces remain");
  AST_LONG_WHOLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (fetch && cfg_width == fpbs_pkg::WID_LONG) |=> o_port_valid && (o_port_data == $past(sw_word)))
    else $error("long read lost part of the word");
  AST_BYTE_BE_FIRST: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (fetch && cfg_width == fpbs_pkg::WID_BYTE && !cfg_little)
      |=> (o_port_data[35:27] == $past(sw_word[35:27])) && (o_lane_valid == 4'h8))
    else $error("first big-endian byte is not A on top lane");
  AST_WORD_LE_SEQ: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (fetch && cfg_width == fpbs_pkg::WID_WORD && cfg_little && !size_change)
      ##1 (shift && !size_change)
      |=> (o_port_data[17:0] == $past(sw_word[35:18], 2)) && (left == 2'h0))
    else $error("little-endian word second piece is not AB");
  AST_BANK_ALT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    fetch |=> (rd_sel != $past(rd_sel)))
    else $error("latch banks not drained alternately");

  COV_BYTE_BE: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    fetch && cfg_width == fpbs_pkg::WID_BYTE && !cfg_little ##1 shift ##1 shift ##1 shift);
  COV_WORD_LE: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    fetch && cfg_width == fpbs_pkg::WID_WORD && cfg_little ##1 shift);
  COV_LONG_B2B: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    fetch && cfg_width == fpbs_pkg::WID_LONG ##1 fetch);
  COV_STALL: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    i_word_valid && !o_word_ready);
endmodule // fpbs_read_sizer

/* hw/fpbs_swap.sv */
/*
  Byte-order arrangement of one whole word, purely combinational.
  Assumes bytes A..D sit from bits 35..27 down to 8..0.
*/
`timescale 1ns/100ps
module fpbs_swap (
  // Word in
  input  wire logic [35:0] i_word,
  // Swap selects {hi, lo}
  input  wire logic [1:0]  i_swap_sel,
  // Arranged word out
  output logic      [35:0] o_word
);
  // Bit order inside each byte is never touched
  always_comb begin
    unique case (i_swap_sel)
      fpbs_pkg::SWAP_NONE:      o_word = i_word;
      fpbs_pkg::SWAP_BYTE:      o_word = {i_word[8:0], i_word[17:9], i_word[26:18], i_word[35:27]};
      fpbs_pkg::SWAP_WORD:      o_word = {i_word[17:0], i_word[35:18]};
      fpbs_pkg::SWAP_BYTE_WORD: o_word = {i_word[26:18], i_word[35:27], i_word[8:0], i_word[17:9]};
    endcase
  end
endmodule // fpbs_swap
